// ==== common/lei_consts.vh ====
`ifndef LEI_CONSTS_VH
`define LEI_CONSTS_VH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define LEI_IDX_LINE_EN      8'h2D
`define LEI_IDX_EVENT_EN     8'h2E
`define LEI_IDX_LINE_STATUS  8'h38
`define LEI_IDX_EVENT_STATUS 8'h39

// ----------------------------------------
// reset values
// ----------------------------------------
`define LEI_RST_LINE_EN      16'h0000
`define LEI_RST_EVENT_EN     16'h0000
`define LEI_RST_STATUS       16'h0000

// ----------------------------------------
// line interface modes
// ----------------------------------------
`define LEI_MODE_EXT_FRAMER  3'h0
`define LEI_MODE_DS3         3'h1
`define LEI_MODE_G751_E3     3'h2
`define LEI_MODE_SONET       3'h3
`define LEI_MODE_G832        3'h4

// ----------------------------------------
// line bits that carry a condition per mode
// ----------------------------------------
`define LEI_LMASK_EXT_FRAMER 16'h7FE1
`define LEI_LMASK_DS3        16'h7FFF
`define LEI_LMASK_G751_E3    16'h7FF7
`define LEI_LMASK_SONET      16'hFFFF
`define LEI_LMASK_G832       16'h7DE5
`define LEI_LMASK_ALWAYS     16'h4001

// ----------------------------------------
// event bit positions
// ----------------------------------------
`define LEI_EV_RCV_HOLD      15
`define LEI_EV_APS           12
`define LEI_EV_SOC_ERR       11
`define LEI_EV_PAR_HI        10
`define LEI_EV_PAR_LO        7
`define LEI_EV_IDLE          6
`define LEI_EV_NO_MATCH      5
`define LEI_EV_GFC           4
`define LEI_EV_PAY_LEN       3
`define LEI_EV_PAY_CRC       2
`define LEI_EV_HEC_UNCOR     1
`define LEI_EV_HEC_COR       0
`define LEI_EV_WRITABLE      16'h9FFF

// ----------------------------------------
// cell header layout
// ----------------------------------------
`define LEI_GFC_HI           31
`define LEI_GFC_LO           28

`endif

// ==== rtl/lei_cell_screen.v ====
`timescale 1ns/100ps
`include "lei_consts.vh"

module lei_cell_screen #(
  parameter NPORTS = 4
) (
  // clock and reset
  input  wire                 hclk,
  input  wire                 hresetn,
  // received cell header
  input  wire                 cell_hdr_valid,
  input  wire [31:0]          cell_hdr,
  // programmed screens
  input  wire [31:0]          idle_header_match_value,
  input  wire [31:0]          idle_header_match_mask,
  input  wire [32*NPORTS-1:0] port_header_match_value,
  input  wire [32*NPORTS-1:0] port_header_match_mask,
  // one-cycle results
  output reg                  idle_hit,
  output reg                  no_match_hit,
  output reg                  gfc_nonzero_hit
);

  // ----------------------------------------
  // masked compare
  // ----------------------------------------
  // a set mask bit makes that header bit a don't-care
  function match_hdr;
    input [31:0] hdr;
    input [31:0] val;
    input [31:0] msk;
    begin
      match_hdr = &((~(hdr ^ val)) | msk);
    end
  endfunction

  reg     any_port;
  reg     is_idle;
  integer i;

  always @* begin
    any_port = 1'b0;
    is_idle  = match_hdr(cell_hdr, idle_header_match_value, idle_header_match_mask);
    for (i = 0; i < NPORTS; i = i + 1) begin
      if (match_hdr(cell_hdr, port_header_match_value[32*i +: 32],
                    port_header_match_mask[32*i +: 32])) begin
        any_port = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // registered event pulses
  // ----------------------------------------
  // idle cells are screened out before port matching, so they never
  // count as non-matching as well
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_hit        <= 1'b0;
      no_match_hit    <= 1'b0;
      gfc_nonzero_hit <= 1'b0;
    end else begin
      idle_hit        <= cell_hdr_valid & is_idle;
      no_match_hit    <= cell_hdr_valid & ~is_idle & ~any_port;
      gfc_nonzero_hit <= cell_hdr_valid &
                         (|cell_hdr[`LEI_GFC_HI:`LEI_GFC_LO]);
    end
  end

endmodule

// ==== rtl/lei_irq.v ====
// How it works
// - a status bit reaches the interrupt only when its same-position enable is set
// - line enable at index 2D gates the line status at index 38
// - event enable at index 2E gates the event status at index 39
// - meaning and validity of each line bit follow the selected line mode
// - set enable lets its condition interrupt; cleared enable blocks it
// - event bit 15 records a high level seen on the receiver hold input
// - event bit 12 records a change of the received K1/K2 bytes
// - event bit 11 records a start-of-cell error on fifo control bit 0
// - event bits 10..7 record port 3..0 parity errors, only with checking on
// - event bit 6 records a cell matching the masked idle header
// - event bit 5 records a non-idle cell matching no masked port header
// - event bit 4 records a cell whose GFC field is not zero
// - event bit 3 records an AAL3/4 payload length error
// - event bit 2 records an AAL3/4 payload CRC error
// - event bit 1 records an uncorrectable HEC error
// - event bit 0 records a corrected HEC error
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
`include "lei_consts.vh"

module lei_irq #(
  parameter NPORTS = 4
) (
  // clock and reset
  input  wire                 hclk,
  input  wire                 hresetn,
  // ahb-lite slave
  input  wire                 hsel,
  input  wire [11:0]          haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output reg  [31:0]          hrdata,
  output wire                 hreadyout,
  output wire                 hresp,
  // line side
  input  wire [2:0]           line_mode,
  input  wire [15:0]          line_cond_in,
  // event sources
  input  wire                 receiver_hold_in,
  input  wire [15:0]          aps_k1k2,
  input  wire                 aps_k1k2_valid,
  input  wire                 fifo_control_in,
  input  wire                 parity_check_en,
  input  wire [NPORTS-1:0]    parity_err_in,
  input  wire                 aal34_mode,
  input  wire                 pay_len_err_in,
  input  wire                 pay_crc_err_in,
  input  wire                 hec_uncor_in,
  input  wire                 hec_cor_in,
  // cell screening
  input  wire                 cell_hdr_valid,
  input  wire [31:0]          cell_hdr,
  input  wire [31:0]          idle_header_match_value,
  input  wire [31:0]          idle_header_match_mask,
  input  wire [32*NPORTS-1:0] port_header_match_value,
  input  wire [32*NPORTS-1:0] port_header_match_mask,
  // other enable/status pairs, already gated
  input  wire                 ovfl_irq_in,
  input  wire                 cell_irq_in,
  // interrupt
  output reg                  stat_irq
);

  // ----------------------------------------
  // line validity per mode
  // ----------------------------------------
  // positions shown as 0 or don't-care in a mode never set status,
  // so stray framer outputs cannot raise an interrupt
  function [15:0] line_valid;
    input [2:0] mode;
    begin
      case (mode)
        `LEI_MODE_EXT_FRAMER: line_valid = `LEI_LMASK_EXT_FRAMER;
        `LEI_MODE_DS3:        line_valid = `LEI_LMASK_DS3;
        `LEI_MODE_G751_E3:    line_valid = `LEI_LMASK_G751_E3;
        `LEI_MODE_SONET:      line_valid = `LEI_LMASK_SONET;
        `LEI_MODE_G832:       line_valid = `LEI_LMASK_G832;
        default:              line_valid = `LEI_LMASK_ALWAYS;
      endcase
    end
  endfunction

  // register index from a byte address
  function [7:0] reg_index;
    input [11:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // write strobe for one register index in the data phase
  function wr_hit;
    input       pend;
    input [7:0] cur;
    input [7:0] idx;
    begin
      wr_hit = pend & (cur == idx);
    end
  endfunction

  // sticky status: a written one clears, but a condition arriving in the
  // same cycle wins so that no event is lost
  function [15:0] w1c_update;
    input [15:0] cur;
    input [15:0] clr;
    input [15:0] set;
    begin
      w1c_update = (cur & ~clr) | set;
    end
  endfunction

  // ----------------------------------------
  // bus state
  // ----------------------------------------
  reg  [15:0] line_irq_enable;
  reg  [15:0] event_irq_enable;
  reg  [15:0] line_status;
  reg  [15:0] event_status;
  reg         wr_pend;
  reg         rd_pend;
  reg  [7:0]  dp_index;
  reg  [15:0] aps_prev;
  reg         aps_seen;

  wire        addr_take;
  wire        wr_line_en;
  wire        wr_event_en;
  wire        wr_line_st;
  wire        wr_event_st;
  wire        idle_hit;
  wire        no_match_hit;
  wire        gfc_nonzero_hit;
  wire [15:0] line_pend_irq;
  wire [15:0] event_pend_irq;

  reg  [15:0] line_set;
  reg  [15:0] event_set;
  reg  [15:0] line_clr;
  reg  [15:0] event_clr;
  reg  [15:0] next_line_status;
  reg  [15:0] next_event_status;
  reg  [31:0] next_hrdata;

  // reads wait one cycle so that a write just before is seen
  assign hreadyout = ~rd_pend;
  assign hresp     = 1'b0;
  assign addr_take = hsel & htrans[1] & hready;

  // a data phase lasts until hready is seen high, so the pending flags
  // advance only then; a read drops its flag after its single wait
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      dp_index <= 8'h00;
    end else begin
      if (hready) begin
        wr_pend <= addr_take & hwrite;
        rd_pend <= addr_take & ~hwrite;
        if (addr_take) begin
          dp_index <= reg_index(haddr);
        end
      end else begin
        rd_pend <= 1'b0;
      end
    end
  end

  assign wr_line_en  = wr_hit(wr_pend, dp_index, `LEI_IDX_LINE_EN);
  assign wr_event_en = wr_hit(wr_pend, dp_index, `LEI_IDX_EVENT_EN);
  assign wr_line_st  = wr_hit(wr_pend, dp_index, `LEI_IDX_LINE_STATUS);
  assign wr_event_st = wr_hit(wr_pend, dp_index, `LEI_IDX_EVENT_STATUS);

  // ----------------------------------------
  // enable registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_irq_enable  <= `LEI_RST_LINE_EN;
      event_irq_enable <= `LEI_RST_EVENT_EN;
    end else begin
      if (wr_line_en) begin
        line_irq_enable <= hwdata[15:0];
      end
      if (wr_event_en) begin
        // reserved bits 14..13 are held at zero whatever is written
        event_irq_enable <= hwdata[15:0] & `LEI_EV_WRITABLE;
      end
    end
  end

  // ----------------------------------------
  // aps byte change detector
  // ----------------------------------------
  // the first K1/K2 after reset only primes the compare; only consecutive
  // strobes are compared, so a value that changes and returns unstrobed
  // raises nothing
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aps_prev <= 16'h0000;
      aps_seen <= 1'b0;
    end else if (aps_k1k2_valid) begin
      aps_prev <= aps_k1k2;
      aps_seen <= 1'b1;
    end
  end

  // ----------------------------------------
  // cell header screening
  // ----------------------------------------
  lei_cell_screen #(
    .NPORTS (NPORTS)
  ) u_screen (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .cell_hdr_valid          (cell_hdr_valid),
    .cell_hdr                (cell_hdr),
    .idle_header_match_value (idle_header_match_value),
    .idle_header_match_mask  (idle_header_match_mask),
    .port_header_match_value (port_header_match_value),
    .port_header_match_mask  (port_header_match_mask),
    .idle_hit                (idle_hit),
    .no_match_hit            (no_match_hit),
    .gfc_nonzero_hit         (gfc_nonzero_hit)
  );

  // ----------------------------------------
  // status set and clear
  // ----------------------------------------
  always @* begin
    line_set = line_cond_in & line_valid(line_mode);
    event_set = 16'h0000;
    event_set[`LEI_EV_RCV_HOLD] = receiver_hold_in;
    event_set[`LEI_EV_APS] = aps_k1k2_valid & aps_seen &
                             (aps_k1k2 != aps_prev);
    event_set[`LEI_EV_SOC_ERR] = fifo_control_in;
    event_set[`LEI_EV_PAR_HI:`LEI_EV_PAR_LO] =
      parity_err_in & {NPORTS{parity_check_en}};
    event_set[`LEI_EV_IDLE] = idle_hit;
    event_set[`LEI_EV_NO_MATCH] = no_match_hit;
    event_set[`LEI_EV_GFC] = gfc_nonzero_hit;
    event_set[`LEI_EV_PAY_LEN] = pay_len_err_in & aal34_mode;
    event_set[`LEI_EV_PAY_CRC] = pay_crc_err_in & aal34_mode;
    event_set[`LEI_EV_HEC_UNCOR] = hec_uncor_in;
    event_set[`LEI_EV_HEC_COR] = hec_cor_in;
    line_clr  = wr_line_st ? hwdata[15:0] : 16'h0000;
    event_clr = wr_event_st ? hwdata[15:0] : 16'h0000;
    next_line_status  = w1c_update(line_status, line_clr, line_set);
    next_event_status = w1c_update(event_status, event_clr, event_set);
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_status  <= `LEI_RST_STATUS;
      event_status <= `LEI_RST_STATUS;
    end else begin
      line_status  <= next_line_status;
      event_status <= next_event_status;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @* begin
    case (dp_index)
      `LEI_IDX_LINE_EN:      next_hrdata = {16'h0000, line_irq_enable};
      `LEI_IDX_EVENT_EN:     next_hrdata = {16'h0000, event_irq_enable};
      `LEI_IDX_LINE_STATUS:  next_hrdata = {16'h0000, line_status};
      `LEI_IDX_EVENT_STATUS: next_hrdata = {16'h0000, event_status};
      default:               next_hrdata = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  // each status bit counts only through the enable at its own position
  assign line_pend_irq  = line_status & line_irq_enable;
  assign event_pend_irq = event_status & event_irq_enable;

  // registered so the pin never glitches on status or enable updates
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_irq <= 1'b0;
    end else begin
      stat_irq <= (|line_pend_irq) |
                  (|event_pend_irq) |
                  ovfl_irq_in | cell_irq_in;
    end
  end

endmodule

// ==== verification/lei_host_model.sv ====
`timescale 1ns/100ps
module lei_host_model (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // interrupt pin and tally
  input  wire        stat_irq,
  output reg  [15:0] irq_count
);
  reg last;
  // the pin is a level: only a rising edge is a new request
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last <= 1'b0;
      irq_count <= 16'h0000;
    end else begin
      last <= stat_irq;
      if (stat_irq && !last)
        irq_count <= irq_count + 16'h0001;
    end
  end
endmodule

// ==== verification/lei_irq_monitor.sv ====
`timescale 1ns/100ps
module lei_irq_monitor (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // interrupt
  input wire        ovfl_irq_in,
  input wire        cell_irq_in,
  input wire        stat_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_go = hsel & htrans[1] & hready & !hwrite;
  wire wr_go = hsel & htrans[1] & hready & hwrite;
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_rd_wait; rd_go |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_rdy; wr_go |=> hreadyout; endproperty
  a_wr_rdy: assert property (p_wr_rdy) else $error("write stalled");
  property p_one_wait; !hreadyout |=> hreadyout; endproperty
  a_one_wait: assert property (p_one_wait) else $error("long wait");
  property p_hi_zero; hreadyout |-> hrdata[31:16] == 16'h0000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
  property p_ovfl; ovfl_irq_in [*2] |=> stat_irq; endproperty
  a_ovfl: assert property (p_ovfl) else $error("ovfl lost");
  property p_cell; cell_irq_in [*2] |=> stat_irq; endproperty
  a_cell: assert property (p_cell) else $error("cell lost");
  property p_fall;
    $fell(stat_irq) |-> (!$past(ovfl_irq_in) || !$past(ovfl_irq_in, 2)) &&
                        (!$past(cell_irq_in) || !$past(cell_irq_in, 2));
  endproperty
  a_fall: assert property (p_fall) else $error("irq fell while held");
endmodule
bind lei_irq lei_irq_monitor lei_irq_monitor_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ovfl_irq_in(ovfl_irq_in), .cell_irq_in(cell_irq_in), .stat_irq(stat_irq));

// ==== verification/line_event_irq_enable_tb_top.sv ====
`timescale 1ns/100ps
`include "lei_consts.vh"
module line_event_irq_enable_tb_top;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg [1:0]  htrans = 0;
  reg [11:0] haddr = 0;
  reg [31:0] hwdata = 0, cell_hdr = 0;
  reg [2:0]  line_mode = 0;
  reg [15:0] line_cond_in = 0, aps_k1k2 = 0;
  reg receiver_hold_in = 0, aps_k1k2_valid = 0, fifo_control_in = 0, parity_check_en = 0;
  reg aal34_mode = 0, pay_len_err_in = 0, pay_crc_err_in = 0, hec_uncor_in = 0;
  reg hec_cor_in = 0, cell_hdr_valid = 0, ovfl_irq_in = 0, cell_irq_in = 0;
  reg [3:0]  parity_err_in = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, stat_irq;
  wire [15:0] irq_count;
  int fails = 0, check_count = 0, cyc = 0, exp_irqs = 0;
  logic [31:0] d;
  logic [15:0] en;
  localparam [11:0] A_LEN = {2'b00, `LEI_IDX_LINE_EN, 2'b00};
  localparam [11:0] A_EEN = {2'b00, `LEI_IDX_EVENT_EN, 2'b00};
  localparam [11:0] A_LST = {2'b00, `LEI_IDX_LINE_STATUS, 2'b00};
  localparam [11:0] A_EST = {2'b00, `LEI_IDX_EVENT_STATUS, 2'b00};
  localparam [15:0] WR = `LEI_EV_WRITABLE;
  always #5 hclk = ~hclk;
  lei_irq lei_irq_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_mode(line_mode),
    .line_cond_in(line_cond_in), .receiver_hold_in(receiver_hold_in), .aps_k1k2(aps_k1k2),
    .aps_k1k2_valid(aps_k1k2_valid), .fifo_control_in(fifo_control_in),
    .parity_check_en(parity_check_en), .parity_err_in(parity_err_in), .aal34_mode(aal34_mode),
    .pay_len_err_in(pay_len_err_in), .pay_crc_err_in(pay_crc_err_in),
    .hec_uncor_in(hec_uncor_in), .hec_cor_in(hec_cor_in), .cell_hdr_valid(cell_hdr_valid),
    .cell_hdr(cell_hdr), .idle_header_match_value(32'h0000_0001),
    .idle_header_match_mask(32'h0000_0000), .port_header_match_value({4{32'h0000_0010}}),
    .port_header_match_mask(128'h0), .ovfl_irq_in(ovfl_irq_in), .cell_irq_in(cell_irq_in),
    .stat_irq(stat_irq));
  lei_host_model lei_host_model_inst (.hclk(hclk), .hresetn(hresetn), .stat_irq(stat_irq),
    .irq_count(irq_count));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic [15:0] lmask(input [2:0] m);
    case (m)
      `LEI_MODE_EXT_FRAMER: lmask = `LEI_LMASK_EXT_FRAMER;
      `LEI_MODE_DS3:        lmask = `LEI_LMASK_DS3;
      `LEI_MODE_G751_E3:    lmask = `LEI_LMASK_G751_E3;
      `LEI_MODE_SONET:      lmask = `LEI_LMASK_SONET;
      `LEI_MODE_G832:       lmask = `LEI_LMASK_G832;
      default:              lmask = `LEI_LMASK_ALWAYS;
    endcase
  endfunction
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // hready and read data are taken at the rising edge that ends the phase
  task wait_rdy(output logic [31:0] v);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    v = hrdata;
  endtask
  task bus(input [11:0] a, input w, input [31:0] wd, output logic [31:0] rd);
    logic [31:0] x;
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy(x);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
  task wr(input [11:0] a, input [31:0] v);
    logic [31:0] x;
    bus(a, 1'b1, v, x);
  endtask
  task irq_is(input logic e);
    @(negedge hclk);
    chk(32'(stat_irq), 32'(e), "stat_irq");
  endtask
  task ev_src(input int b, input logic v);
    case (b)
      15: receiver_hold_in <= v;
      12: begin
        aps_k1k2_valid <= v;
        if (v)
          aps_k1k2 <= aps_k1k2 ^ 16'($urandom_range(16'hFFFF, 1));
      end
      11: fifo_control_in <= v;
      6: begin cell_hdr_valid <= v; cell_hdr <= 32'h0000_0001; end
      5: begin cell_hdr_valid <= v; cell_hdr <= 32'h0000_0002; end
      4: begin cell_hdr_valid <= v; cell_hdr <= 32'hA000_0010; end
      3: pay_len_err_in <= v;
      2: pay_crc_err_in <= v;
      1: hec_uncor_in <= v;
      0: hec_cor_in <= v;
      default: parity_err_in[b-7] <= v;
    endcase
  endtask
  task pulse(input int b);
    @(posedge hclk) ev_src(b, 1'b1);
    @(posedge hclk) ev_src(b, 1'b0);
    repeat (3) @(posedge hclk);
  endtask
  task ev_case(input int b, input logic gate, input logic e);
    wr(A_EEN, 32'h1 << b);
    parity_check_en <= gate;
    aal34_mode <= gate;
    pulse(b);
    irq_is(e);
    bus(A_EST, 1'b0, 0, d);
    chk(32'(d[b]), 32'(e), "event bit");
    wr(A_EEN, 0);
    repeat (2) @(posedge hclk);
    irq_is(1'b0);
    bus(A_EST, 1'b0, 0, d);
    chk(32'(d[b]), 32'(e), "status kept");
    wr(A_EST, 32'hFFFF);
    exp_irqs += e;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h057D0877));
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    bus(A_LEN, 1'b0, 0, d); chk(d, 0, "line en reset");
    bus(A_EEN, 1'b0, 0, d); chk(d, 0, "event en reset");
    bus(A_LST, 1'b0, 0, d); chk(d, 0, "line status reset");
    bus(A_EST, 1'b0, 0, d); chk(d, 0, "event status reset");
    wr(A_EEN, 32'hFFFF_FFFF);
    bus(A_EEN, 1'b0, 0, d); chk(d, 32'(WR), "event en mask");
    wr(12'h100, 32'hFFFF);
    bus(12'h100, 1'b0, 0, d); chk(d, 0, "unmapped");
    wr(A_EEN, 0);
    $display("test registers done");
    pulse(12);
    wr(A_EST, 32'hFFFF);
    for (int b = 0; b < 16; b++) begin
      if (WR[b]) begin
        if ((b >= 7 && b <= 10) || b == 2 || b == 3)
          ev_case(b, 1'b0, 1'b0);
        ev_case(b, 1'b1, 1'b1);
      end
    end
    $display("test events done");
    for (int m = 0; m < 8; m++) begin
      en = 16'($urandom);
      line_mode <= 3'(m);
      wr(A_LEN, {16'h0, en});
      bus(A_LEN, 1'b0, 0, d); chk(d, {16'h0, en}, "line en");
      @(posedge hclk) line_cond_in <= 16'hFFFF;
      @(posedge hclk) line_cond_in <= 16'h0000;
      repeat (3) @(posedge hclk);
      irq_is(|(lmask(3'(m)) & en));
      bus(A_LST, 1'b0, 0, d); chk(d, {16'h0, lmask(3'(m))}, "line status");
      exp_irqs += |(lmask(3'(m)) & en);
      wr(A_LEN, 0);
      wr(A_LST, 32'hFFFF);
    end
    $display("test line modes done");
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk) {ovfl_irq_in, cell_irq_in} <= k ? 2'b01 : 2'b10;
      repeat (3) @(posedge hclk);
      irq_is(1'b1);
      @(posedge hclk) {ovfl_irq_in, cell_irq_in} <= 2'b00;
      repeat (3) @(posedge hclk);
      irq_is(1'b0);
      exp_irqs++;
    end
    chk(32'(irq_count), 32'(exp_irqs), "irq count");
    $display("test other pairs done");
    test_done;
  end
endmodule
